// *** asc_ctrl.sv ***
`timescale 1ns/1ns
// Operation
// - Write starts only when strobe, select and a lane enable are all active.
// - Host keeps write data set up and held about the ending edge.
// - Strobe-ended write with output enable low lasts float delay plus setup.
// - Host drives every select pin to a valid level at all times.
// - Deselect by inactive selects or by both lanes inactive.
module asc_ctrl
	import asc_pkg::*;
#(
	parameter int ADDR_W = 18,
	parameter int DATA_W = 16
) (
	// Clock and reset
	input wire logic CORE_CLK_I,
	input wire logic SYS_RST_I,
	// User request port
	input wire logic REQ_VALID_I,
	input wire asc_pkg::asc_req_t REQ_I,
	output logic REQ_READY_O,
	output logic RD_VALID_O,
	output logic [DATA_W-1:0] RD_DATA_O,
	// Memory control pins
	output asc_pkg::asc_ctl_t MEM_CTL_O,
	output logic [ADDR_W-1:0] MEM_ADDR_O,
	// Memory data pins
	input wire logic [DATA_W-1:0] MEM_DQ_I,
	output logic [DATA_W-1:0] MEM_DQ_O,
	output logic [1:0] MEM_DQ_OE_O
);

	import asc_pkg::*;

	asc_state_t state_r;
	asc_state_t state_nxt;
	logic [ASC_CNT_W-1:0] cnt_r;
	logic [ASC_CNT_W-1:0] cnt_nxt;
	logic [1:0] lane_r;
	logic [DATA_W-1:0] dq_sync;
	logic take;

	// Lane mask: enabled lanes see pin data, others keep zero
	function automatic logic [DATA_W-1:0] lane_mask(input logic [1:0] lane_n);
		lane_mask = {{(DATA_W/2){~lane_n[1]}}, {(DATA_W/2){~lane_n[0]}}};
	endfunction : lane_mask

	// ==========================================================
	// Input synchroniser
	asc_sync #(
		.WIDTH(DATA_W)
	) u_sync (
		.clk_i(CORE_CLK_I),
		.rst_i(SYS_RST_I),
		.d_i(MEM_DQ_I),
		.q_o(dq_sync)
	);

	// A request with both lanes off would be a deselect, so it is simply retired
	assign take = REQ_VALID_I && REQ_READY_O;

	// ==========================================================
	// Sequencer
	always_comb
	begin
		state_nxt = state_r;
		cnt_nxt = (cnt_r != '0) ? cnt_r - 1'b1 : cnt_r;
		unique case (state_r)
			ASC_IDLE:
			begin
				if (take && REQ_I.lane_n != ASC_LANES_OFF)
				begin
					state_nxt = REQ_I.write ? ASC_WSTROBE : ASC_READ;
					cnt_nxt = REQ_I.write ? ASC_CNT_W'(ASC_WR_CYC - 1) :
						ASC_CNT_W'(ASC_RD_CYC - 1);
				end
			end
			ASC_WSTROBE:
			begin
				if (cnt_r == '0)
				begin
					state_nxt = ASC_WHOLD;
					cnt_nxt = ASC_CNT_W'(ASC_HOLD_CYC - 1);
				end
			end
			ASC_WHOLD:
			begin
				if (cnt_r == '0)
					state_nxt = ASC_IDLE;
			end
			ASC_READ:
			begin
				if (cnt_r == '0)
				begin
					state_nxt = ASC_TURN;
					cnt_nxt = ASC_CNT_W'(ASC_TURN_CYC - 1);
				end
			end
			ASC_TURN:
			begin
				if (cnt_r == '0)
					state_nxt = ASC_IDLE;
			end
			default:
			begin
				state_nxt = ASC_IDLE;
			end
		endcase
	end

	// State and counter registers
	always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I)
	begin
		if (SYS_RST_I)
		begin
			state_r <= ASC_IDLE;
			cnt_r <= '0;
		end
		else
		begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// Ready only in idle; rises on the same edge as the previous access retires
	always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I)
	begin
		if (SYS_RST_I)
			REQ_READY_O <= 1'b0;
		else
			REQ_READY_O <= (state_nxt == ASC_IDLE) && !take;
	end

	// ==========================================================
	// Pin drivers; selects always at full levels, never floated
	always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I)
	begin
		if (SYS_RST_I)
		begin
			MEM_CTL_O <= '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
			MEM_ADDR_O <= '0;
			MEM_DQ_O <= '0;
			MEM_DQ_OE_O <= 2'h0;
			lane_r <= ASC_LANES_OFF;
		end
		else
		begin
			if (state_r == ASC_IDLE && take)
			begin
				MEM_ADDR_O <= REQ_I.addr;
				MEM_DQ_O <= REQ_I.wdata;
				lane_r <= REQ_I.lane_n;
			end
			unique case (state_nxt)
				ASC_WSTROBE:
				begin
					// All window terms asserted together; write-enable held
					// at least float delay plus data setup
					MEM_CTL_O.select_primary_n <= 1'b0;
					MEM_CTL_O.select_secondary <= 1'b1;
					MEM_CTL_O.write_n <= 1'b0;
					MEM_CTL_O.out_en_n <= 1'b1;
					MEM_CTL_O.upper_lane_en_n <= (state_r == ASC_IDLE) ?
						REQ_I.lane_n[1] : lane_r[1];
					MEM_CTL_O.lower_lane_en_n <= (state_r == ASC_IDLE) ?
						REQ_I.lane_n[0] : lane_r[0];
					// Drive only the enabled lanes
					MEM_DQ_OE_O <= (state_r == ASC_IDLE) ? ~REQ_I.lane_n : ~lane_r;
				end
				ASC_WHOLD:
				begin
					// Strobe ends the window; data and address held past it
					MEM_CTL_O.write_n <= 1'b1;
				end
				ASC_READ:
				begin
					MEM_CTL_O.select_primary_n <= 1'b0;
					MEM_CTL_O.select_secondary <= 1'b1;
					MEM_CTL_O.write_n <= 1'b1;
					MEM_CTL_O.out_en_n <= 1'b0;
					MEM_CTL_O.upper_lane_en_n <= (state_r == ASC_IDLE) ?
						REQ_I.lane_n[1] : lane_r[1];
					MEM_CTL_O.lower_lane_en_n <= (state_r == ASC_IDLE) ?
						REQ_I.lane_n[0] : lane_r[0];
					MEM_DQ_OE_O <= 2'h0;
				end
				default:
				begin
					// Idle and turnaround: deselect by both means
					MEM_CTL_O <= '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
					MEM_DQ_OE_O <= 2'h0;
				end
			endcase
		end
	end

	// ==========================================================
	// Read capture of the pin word sampled on the last read edge, a full read
	// cycle after select; the two sync stages delay it two turn cycles.
	// Floated lanes read zero.
	always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I)
	begin
		if (SYS_RST_I)
		begin
			RD_VALID_O <= 1'b0;
			RD_DATA_O <= '0;
		end
		else
		begin
			RD_VALID_O <= (state_r == ASC_TURN) && (cnt_r == ASC_CNT_W'(ASC_TURN_CYC - 2));
			if ((state_r == ASC_TURN) && (cnt_r == ASC_CNT_W'(ASC_TURN_CYC - 2)))
				RD_DATA_O <= dq_sync & lane_mask(lane_r);
		end
	end

endmodule : asc_ctrl

// *** asc_ctrl_asserts.sv ***
`timescale 1ns/1ns
// ==========
// Pin protocol checker
module asc_ctrl_chk
	import asc_pkg::*;
#(
	parameter int ADDR_W = 18,
	parameter int DATA_W = 16
) (
	// Clock, reset, user side
	input wire logic CORE_CLK_I,
	input wire logic SYS_RST_I,
	input wire logic REQ_VALID_I,
	input asc_pkg::asc_req_t REQ_I,
	input wire logic REQ_READY_O,
	input wire logic RD_VALID_O,
	input wire logic [DATA_W-1:0] RD_DATA_O,
	// Memory pins
	input asc_pkg::asc_ctl_t MEM_CTL_O,
	input wire logic [ADDR_W-1:0] MEM_ADDR_O,
	input wire logic [DATA_W-1:0] MEM_DQ_I,
	input wire logic [DATA_W-1:0] MEM_DQ_O,
	input wire logic [1:0] MEM_DQ_OE_O
);
	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (SYS_RST_I);
	// Decoded pin views
	wire logic sel = !MEM_CTL_O.select_primary_n && MEM_CTL_O.select_secondary;
	wire logic wn = MEM_CTL_O.write_n;
	wire logic [1:0] ln = {MEM_CTL_O.upper_lane_en_n, MEM_CTL_O.lower_lane_en_n};
	wire logic take = REQ_VALID_I && REQ_READY_O;
	a_select_pair: assert property (MEM_CTL_O.select_primary_n == !MEM_CTL_O.select_secondary)
		else $error("select pins disagree");
	a_write_window: assert property (!wn |-> sel && ln != 2'h3)
		else $error("strobe outside window");
	a_read_no_drive: assert property (!MEM_CTL_O.out_en_n |-> MEM_DQ_OE_O == 2'h0)
		else $error("drive during read");
	a_lane_drive: assert property (MEM_DQ_OE_O != 2'h0 |-> sel && MEM_DQ_OE_O == ~ln)
		else $error("drive lanes wrong");
	a_strobe_width: assert property ($fell(wn) |-> !wn [*8] ##1 !wn [*3] ##1 wn)
		else $error("strobe width wrong");
	a_data_hold: assert property ($rose(wn) |-> sel && $stable(MEM_DQ_O) && $stable(MEM_DQ_OE_O))
		else $error("data not held");
	a_read_time: assert property (take && !REQ_I.write && REQ_I.lane_n != 2'h3 |-> ##15 RD_VALID_O)
		else $error("read answer late");
	a_quiet_lanes: assert property (take && REQ_I.lane_n == 2'h3 |=> !sel [*2])
		else $error("pins busy for empty lanes");
	// Main scenarios seen
	c_write: cover property ($fell(wn));
	c_read: cover property (RD_VALID_O);
	c_low_byte: cover property (MEM_DQ_OE_O == 2'h1);
endmodule : asc_ctrl_chk

bind asc_ctrl asc_ctrl_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_chk (.CORE_CLK_I(CORE_CLK_I),
	.SYS_RST_I(SYS_RST_I), .REQ_VALID_I(REQ_VALID_I), .REQ_I(REQ_I), .REQ_READY_O(REQ_READY_O),
	.RD_VALID_O(RD_VALID_O), .RD_DATA_O(RD_DATA_O), .MEM_CTL_O(MEM_CTL_O), .MEM_ADDR_O(MEM_ADDR_O),
	.MEM_DQ_I(MEM_DQ_I), .MEM_DQ_O(MEM_DQ_O), .MEM_DQ_OE_O(MEM_DQ_OE_O));

// *** asc_pkg.sv ***
package asc_pkg;

	// ==========================================================
	// Geometry
	localparam int ASC_ADDR_W = 18;
	localparam int ASC_DATA_W = 16;
	localparam int ASC_LANE_W = 8;

	// ==========================================================
	// Timing
	localparam int ASC_CLK_PERIOD_NS = 4;
	localparam int ASC_ADDR_SETUP_NS = 0;
	localparam int ASC_WRITE_PULSE_NS = 35;
	localparam int ASC_STROBE_TO_FLOAT_DELAY_NS = 18;
	localparam int ASC_WRITE_DATA_SETUP_TIME_NS = 25;
	localparam int ASC_DATA_HOLD_NS = 0;
	localparam int ASC_READ_CYCLE_NS = 45;
	localparam int ASC_TURN_NS = 18;
	localparam int ASC_PULSE_MIN_NS = (ASC_WRITE_PULSE_NS >
		(ASC_STROBE_TO_FLOAT_DELAY_NS + ASC_WRITE_DATA_SETUP_TIME_NS)) ?
		ASC_WRITE_PULSE_NS :
		(ASC_STROBE_TO_FLOAT_DELAY_NS + ASC_WRITE_DATA_SETUP_TIME_NS);
	localparam int ASC_WR_CYC = (ASC_PULSE_MIN_NS + ASC_CLK_PERIOD_NS - 1) / ASC_CLK_PERIOD_NS;
	localparam int ASC_RD_CYC = (ASC_READ_CYCLE_NS + ASC_CLK_PERIOD_NS - 1) / ASC_CLK_PERIOD_NS;
	localparam int ASC_TURN_CYC = (ASC_TURN_NS + ASC_CLK_PERIOD_NS - 1) / ASC_CLK_PERIOD_NS;
	localparam int ASC_HOLD_CYC = 1;
	localparam int ASC_CNT_W = 8;

	// ==========================================================
	// Reset values
	localparam logic [1:0] ASC_LANES_OFF = 2'h3;

	// ==========================================================
	// Types
	typedef struct packed {
		logic write;
		logic [1:0] lane_n;
		logic [ASC_ADDR_W-1:0] addr;
		logic [ASC_DATA_W-1:0] wdata;
	} asc_req_t;

	typedef struct packed {
		logic select_primary_n;
		logic select_secondary;
		logic write_n;
		logic out_en_n;
		logic upper_lane_en_n;
		logic lower_lane_en_n;
	} asc_ctl_t;

	typedef enum logic [4:0] {
		ASC_IDLE = 5'h01,
		ASC_WSTROBE = 5'h02,
		ASC_WHOLD = 5'h04,
		ASC_READ = 5'h08,
		ASC_TURN = 5'h10
	} asc_state_t;

endpackage : asc_pkg

// *** asc_sram_model.sv ***
`timescale 1ns/1ns
// ==========
// Behavioural static memory behind the pins
module asc_sram_model
	import asc_pkg::*;
(
	// Pins from the controller
	input asc_pkg::asc_ctl_t ctl_i,
	input wire logic [17:0] addr_i,
	input wire logic [15:0] dq_i,
	// Pins back to the controller
	output logic [15:0] dq_o,
	output logic [1:0] drive_o
);
	logic [15:0] mem [int]; // Sparse, so 256K words cost nothing
	logic [15:0] word;
	wire logic sel = !ctl_i.select_primary_n && ctl_i.select_secondary;
	wire logic [1:0] lane = ~{ctl_i.upper_lane_en_n, ctl_i.lower_lane_en_n};
	// Level write while the window lasts; a floated lane shows the inverse to expose stale reads
	always @(ctl_i or addr_i or dq_i)
	begin
		word = mem.exists(addr_i) ? mem[addr_i] : 16'h0000;
		if (sel && !ctl_i.write_n && lane != 2'h0)
		begin
			if (lane[0]) word[7:0] = dq_i[7:0];
			if (lane[1]) word[15:8] = dq_i[15:8];
			mem[addr_i] = word;
		end
		drive_o = (sel && ctl_i.write_n && !ctl_i.out_en_n) ? lane : 2'h0;
		dq_o = word ^ {{8{!drive_o[1]}}, {8{!drive_o[0]}}};
	end
endmodule : asc_sram_model

// *** asc_sync.sv ***
`timescale 1ns/1ns
// Two-stage synchroniser for the pin data returned by the memory
module asc_sync #(
	parameter int WIDTH = 16
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);

	logic [WIDTH-1:0] meta_r;

	// ==========================================================
	// First stage is read only by the second
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			meta_r <= '0;
			q_o <= '0;
		end
		else
		begin
			meta_r <= d_i;
			q_o <= meta_r;
		end
	end

endmodule : asc_sync

// *** async_sram_word_byte_access_test.sv ***
`timescale 1ns/1ns
// ==========
// Random word and byte traffic against a reference array
module async_sram_word_byte_access_test;
	import asc_pkg::*;
	logic clk = 1'b0, rst = 1'b1, vld = 1'b0, rdy, rv;
	int n_fail = 0, cmp_count = 0, seed = 32'h05A616FE, i, r;
	asc_req_t req = '0;
	asc_ctl_t ctl;
	logic [17:0] addr;
	logic [15:0] rdat, dq_o, m_dq, dq;
	logic [1:0] oe, m_drv;
	logic [15:0] ref_mem [int];
	always #2 clk = ~clk;
	// Wire level per lane: whoever enables drives it
	assign dq = {oe[1] ? dq_o[15:8] : m_dq[15:8], oe[0] ? dq_o[7:0] : m_dq[7:0]};
	asc_ctrl uut (.CORE_CLK_I(clk), .SYS_RST_I(rst), .REQ_VALID_I(vld), .REQ_I(req),
		.REQ_READY_O(rdy), .RD_VALID_O(rv), .RD_DATA_O(rdat), .MEM_CTL_O(ctl),
		.MEM_ADDR_O(addr), .MEM_DQ_I(dq), .MEM_DQ_O(dq_o), .MEM_DQ_OE_O(oe));
	asc_sram_model u_mem (.ctl_i(ctl), .addr_i(addr), .dq_i(dq), .dq_o(m_dq), .drive_o(m_drv));
	task close_out;
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : close_out
	task check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	// No lane may be driven from both ends at once
	always @(negedge clk)
		if (!rst)
			check({14'h0000, oe & m_drv}, 16'h0000);
	// Wait for a sampled-high flag, giving up after a bound
	task automatic wait_hi(input bit pick_rv);
		int k;
		k = 0;
		do
		begin
			@(posedge clk);
			k++;
		end while ((pick_rv ? rv : rdy) !== 1'b1 && k < 40);
		if ((pick_rv ? rv : rdy) !== 1'b1)
		begin
			n_fail++;
			close_out;
		end
	endtask : wait_hi
	// One request held until taken; reads compared with the reference
	task xfer(input logic w, input logic [1:0] ln, input logic [17:0] a, input logic [15:0] d);
		logic [15:0] e;
		e = ref_mem.exists(a) ? ref_mem[a] : 16'h0000;
		@(negedge clk);
		vld = 1'b1;
		req = '{w, ln, a, d};
		wait_hi(1'b0);
		@(negedge clk);
		vld = 1'b0;
		if (w)
		begin
			if (!ln[0]) e[7:0] = d[7:0];
			if (!ln[1]) e[15:8] = d[15:8];
			ref_mem[a] = e;
		end
		else
		begin
			wait_hi(1'b1);
			check(rdat, e & {{8{!ln[1]}}, {8{!ln[0]}}});
		end
	endtask : xfer
	// Reset, pin idle levels, then random mixed traffic on a few addresses
	initial
	begin
		repeat (3) @(negedge clk);
		check({10'h000, ctl}, 16'h002F);
		rst = 1'b0;
		for (i = 0; i < 80; i++)
		begin
			r = $random(seed);
			if (!r[0] && r[2:1] == 2'h3) r[2:1] = 2'h0;
			xfer(r[0], r[2:1], {r[8], 14'h0000, r[5:3]}, r[31:16]);
		end
		close_out;
	end
endmodule : async_sram_word_byte_access_test
